// File: hw/dsef_core.v
// security command interpreter with AHB-Lite register slave
// Summary of operation
// - erase aborts unless prepare immediately preceded
// - sector: word0 bit0 selects, words 1-16 password
// - erase password mismatch aborts, erases nothing
// - good erase wipes whole user area
// - good erase clears lock-enable, keeps master
// - freeze-lock sets frozen state
// - frozen rejects all lock-changing commands
// - only power-on or hard reset unfreezes
// - freeze while frozen completes, stays frozen
// - disable-password aborted while locked
// - disable matches user or master, clears lock-enable
// - monitoring operation chosen by feature register
// - decode monitoring features D0h to DBh, except D7h
// - erase-prepare arms erase-unit
// - unlock tries start five; zero blocks unlock and erase
`timescale 1ns/100ps
`include "dsef_regs.vh"
module dsef_core (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        ce,
  // hard reset pin, active low
  input  wire        hardRstn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // command completion
  output reg         cmdDone,
  output reg         cmdErr,
  // media erase request
  output reg         eraseAll,
  // monitoring subcommand
  output reg         smartGo,
  output reg  [3:0]  smartOp
);
  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_IDLE  = 2'h0;  // waiting for a command
  localparam [1:0] ST_RECV  = 2'h1;  // taking the password sector
  localparam [1:0] ST_CHECK = 2'h2;  // deciding the result

  // ****************************************
  // declarations
  // ****************************************
  reg         pend_reg;      // data phase outstanding
  reg         pWr_reg;       // pending access is a write
  reg  [7:0]  pAddr_reg;     // pending byte offset
  reg  [1:0]  state_reg;     // command state
  reg  [7:0]  opc_reg;       // opcode in progress
  reg  [7:0]  wordCnt_reg;   // sector word index
  reg         sel_reg;       // master password selected
  reg         cmpVld_reg;    // a compare is due
  reg  [15:0] cmpWord_reg;   // received password word
  reg         userBad_reg;   // mismatch against user
  reg         mastBad_reg;   // mismatch against master
  reg         locked_reg;    // drive locked
  reg         lockEn_reg;    // lock function enabled
  reg         frozen_reg;    // frozen mode
  reg         armed_reg;     // erase-unit armed
  reg  [2:0]  tries_reg;     // unlock attempts left
  reg         err_reg;       // status error bit
  reg         abrt_reg;      // error register abort bit
  reg         hr1_reg;       // hard reset sync stage 1
  reg         hr2_reg;       // hard reset sync stage 2
  wire        hardHit;
  wire        take;
  wire        stall;
  wire        fin;
  wire        doWr;
  wire        cmdWr;
  wire        inPush;
  wire        fInRdy;
  wire        fOutVld;
  wire [15:0] fOutData;
  wire        popWord;
  wire [31:0] pwdRd;
  wire [3:0]  rdIdx;
  wire        pwWord;
  wire [7:0]  opc;
  wire [7:0]  feat;
  wire        ftOk;
  reg  [31:0] rdMux;
  reg         rej;           // issue-time rejection
  reg         needSec;       // command takes a sector

  // ****************************************
  // bus decode
  // ****************************************
  assign take   = hsel & htrans[1] & hready & ~pend_reg;
  assign stall  = pWr_reg & (pAddr_reg == `DSEF_OFS_DATA) &
                  (state_reg == ST_RECV) & ~fInRdy;
  assign fin    = pend_reg & ~stall;
  assign doWr   = fin & pWr_reg;
  assign cmdWr  = doWr & (pAddr_reg == `DSEF_OFS_CMD) &
                  (state_reg == ST_IDLE);
  assign inPush = doWr & (pAddr_reg == `DSEF_OFS_DATA) &
                  (state_reg == ST_RECV);
  assign opc    = hwdata[7:0];
  assign feat   = hwdata[15:8];
  assign hardHit = ~hr2_reg;

  // ****************************************
  // sector path
  // ****************************************
  assign popWord = fOutVld & (state_reg == ST_RECV);
  assign pwWord  = (wordCnt_reg >= `DSEF_PW_FIRST) &
                   (wordCnt_reg <= `DSEF_PW_LAST);
  assign rdIdx   = wordCnt_reg[3:0] - 4'h1;

  // monitoring feature inside D0h..D6h or D8h..DBh
  assign ftOk = ((feat >= `DSEF_FT_FIRST) & (feat <= `DSEF_FT_LOGW)) |
                ((feat >= `DSEF_FT_ENA) & (feat <= `DSEF_FT_LAST));

  // buffer between bus writes and the compare
  dsef_fifo2 uBuf (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .inValid  (inPush),
    .inReady  (fInRdy),
    .inData   (hwdata[15:0]),
    .outValid (fOutVld),
    .outReady (state_reg == ST_RECV),
    .outData  (fOutData)
  );

  // stored passwords, loaded by firmware
  dsef_pwd_mem uPwd (
    .core_clk (core_clk),
    .ce       (ce),
    .wrUser   (doWr & (pAddr_reg == `DSEF_OFS_PWD) & ~hwdata[`DSEF_PW_MASTER]),
    .wrMaster (doWr & (pAddr_reg == `DSEF_OFS_PWD) & hwdata[`DSEF_PW_MASTER]),
    .wrAddr   (hwdata[`DSEF_PW_IDX_LO+3:`DSEF_PW_IDX_LO]),
    .wrData   (hwdata[15:0]),
    .rdAddr   (rdIdx),
    .rdData   (pwdRd)
  );

  // ****************************************
  // issue-time checks
  // ****************************************
  // decides rejection and whether a sector follows
  always @* begin
    rej     = 1'b0;
    needSec = 1'b0;
    case (opc)
      `DSEF_OP_SETPW: begin
        rej = frozen_reg;
      end
      `DSEF_OP_UNLOCK: begin
        rej = frozen_reg | (tries_reg == 3'h0);
      end
      `DSEF_OP_EPREP: begin
        rej = frozen_reg;
      end
      `DSEF_OP_ERASE: begin
        // unarmed, frozen or out of tries
        rej = ~armed_reg | frozen_reg | (tries_reg == 3'h0);
        needSec = ~rej;
      end
      `DSEF_OP_FREEZE: begin
        rej = 1'b0;
      end
      `DSEF_OP_DISPW: begin
        rej = frozen_reg | locked_reg;
        needSec = ~rej;
      end
      `DSEF_OP_SMART: begin
        rej = ~ftOk;
      end
      default: begin
        rej = 1'b1;
      end
    endcase
  end

  // read data selection
  always @* begin
    rdMux = 32'h0000_0000;
    case (pAddr_reg)
      `DSEF_OFS_STAT: begin
        rdMux[`DSEF_ST_BUSY]   = (state_reg != ST_IDLE);
        rdMux[`DSEF_ST_DRQ]    = (state_reg == ST_RECV);
        rdMux[`DSEF_ST_ERR]    = err_reg;
        rdMux[`DSEF_ST_ABRT]   = abrt_reg;
        rdMux[`DSEF_ST_LOCKED] = locked_reg;
        rdMux[`DSEF_ST_LOCKEN] = lockEn_reg;
        rdMux[`DSEF_ST_FROZEN] = frozen_reg;
        rdMux[`DSEF_ST_ARMED]  = armed_reg;
        rdMux[`DSEF_ST_TRY_LO+2:`DSEF_ST_TRY_LO] = tries_reg;
        rdMux[`DSEF_ST_OP_LO+3:`DSEF_ST_OP_LO]   = smartOp;
      end
      `DSEF_OFS_CTRL: begin
        rdMux[`DSEF_CT_LOCKEN] = lockEn_reg;
        rdMux[`DSEF_CT_LOCKED] = locked_reg;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************
  // hard reset synchroniser
  // ****************************************
  // pin passes two flops before use
  always @(posedge core_clk) begin
    if (!rstn) begin
      hr1_reg <= 1'b1;
      hr2_reg <= 1'b1;
    end else if (ce) begin
      hr1_reg <= hardRstn;
      hr2_reg <= hr1_reg;
    end
  end

  // ****************************************
  // AHB-Lite slave: one wait state per transfer, more while a sector word write finds the buffer full
  // ****************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      pend_reg  <= 1'b0;
      pWr_reg   <= 1'b0;
      pAddr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
      if (take) begin
        // address phase taken, insert wait
        pend_reg  <= 1'b1;
        pWr_reg   <= hwrite;
        pAddr_reg <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (fin) begin
        // data phase ends; stalls while the buffer is full
        pend_reg  <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= pWr_reg ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // ****************************************
  // command state machine and security state
  // ****************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      opc_reg     <= 8'h00;
      wordCnt_reg <= 8'h00;
      sel_reg     <= 1'b0;
      cmpVld_reg  <= 1'b0;
      cmpWord_reg <= 16'h0000;
      userBad_reg <= 1'b0;
      mastBad_reg <= 1'b0;
      locked_reg  <= 1'b0;
      lockEn_reg  <= 1'b0;
      frozen_reg  <= 1'b0;
      armed_reg   <= 1'b0;
      tries_reg   <= `DSEF_TRIES;
      err_reg     <= 1'b0;
      abrt_reg    <= 1'b0;
      cmdDone     <= 1'b0;
      cmdErr      <= 1'b0;
      eraseAll    <= 1'b0;
      smartGo     <= 1'b0;
      smartOp     <= 4'h0;
    end else if (ce) begin
      cmdDone  <= 1'b0;
      eraseAll <= 1'b0;
      smartGo  <= 1'b0;
      // firmware reports lock state and failed unlocks
      if (doWr & (pAddr_reg == `DSEF_OFS_CTRL)) begin
        lockEn_reg <= hwdata[`DSEF_CT_LOCKEN];
        locked_reg <= hwdata[`DSEF_CT_LOCKED];
        if (hwdata[`DSEF_CT_MISS] & (tries_reg != 3'h0)) begin
          tries_reg <= tries_reg - 3'h1;
        end
      end
      // compare stage, one cycle after the memory read
      if (cmpVld_reg) begin
        userBad_reg <= userBad_reg | (cmpWord_reg != pwdRd[15:0]);
        mastBad_reg <= mastBad_reg | (cmpWord_reg != pwdRd[31:16]);
      end
      cmpVld_reg <= popWord & pwWord;
      cmpWord_reg <= fOutData;
      case (state_reg)
        ST_IDLE: begin
          if (cmdWr) begin
            opc_reg     <= opc;
            wordCnt_reg <= 8'h00;
            userBad_reg <= 1'b0;
            mastBad_reg <= 1'b0;
            err_reg     <= rej;
            abrt_reg    <= rej;
            // any command but a good prepare disarms
            armed_reg <= (opc == `DSEF_OP_EPREP) & ~rej;
            if (needSec) begin
              state_reg <= ST_RECV;
            end else begin
              cmdDone <= 1'b1;
              cmdErr  <= rej;
              if ((opc == `DSEF_OP_FREEZE) & ~rej) begin
                frozen_reg <= 1'b1;
              end
              if ((opc == `DSEF_OP_SMART) & ~rej) begin
                smartOp <= feat[3:0];
                smartGo <= 1'b1;
              end
            end
          end
        end
        ST_RECV: begin
          if (popWord) begin
            if (wordCnt_reg == 8'h00) begin
              sel_reg <= fOutData[0];
            end
            wordCnt_reg <= wordCnt_reg + 8'h01;
            if (wordCnt_reg == `DSEF_WORD_LAST) begin
              state_reg <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          state_reg <= ST_IDLE;
          cmdDone   <= 1'b1;
          if (opc_reg == `DSEF_OP_ERASE) begin
            if (sel_reg ? mastBad_reg : userBad_reg) begin
              err_reg  <= 1'b1;
              abrt_reg <= 1'b1;
              cmdErr   <= 1'b1;
            end else begin
              eraseAll   <= 1'b1;
              lockEn_reg <= 1'b0;
              locked_reg <= 1'b0;
              cmdErr     <= 1'b0;
            end
          end else begin
            if (userBad_reg & mastBad_reg) begin
              err_reg  <= 1'b1;
              abrt_reg <= 1'b1;
              cmdErr   <= 1'b1;
            end else begin
              lockEn_reg <= 1'b0;
              cmdErr     <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // hard reset: leave frozen mode, restore tries
      if (hardHit) begin
        frozen_reg <= 1'b0;
        tries_reg  <= `DSEF_TRIES;
        armed_reg  <= 1'b0;
      end
    end
  end
endmodule

// File: hw/dsef_fifo2.v
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
module dsef_fifo2 (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        ce,
  // filling side
  input  wire        inValid,
  output wire        inReady,
  input  wire [15:0] inData,
  // draining side
  output wire        outValid,
  input  wire        outReady,
  output wire [15:0] outData
);
  reg  [15:0] slot_reg [0:1];  // storage
  reg         wrPtr_reg;       // next slot to fill
  reg         rdPtr_reg;       // next slot to drain
  reg  [1:0]  cnt_reg;         // words held
  wire        push;
  wire        pop;
  assign inReady  = (cnt_reg != 2'h2);
  assign outValid = (cnt_reg != 2'h0);
  assign outData  = slot_reg[rdPtr_reg];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  // pointers and count; storage written on push
  always @(posedge core_clk) begin
    if (!rstn) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      cnt_reg   <= 2'h0;
    end else if (ce) begin
      if (push) begin
        slot_reg[wrPtr_reg] <= inData;
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// File: hw/dsef_pwd_mem.v
// stored password words: user half low, master half high, registered read
`timescale 1ns/100ps
module dsef_pwd_mem (
  // clock
  input  wire        core_clk,
  input  wire        ce,
  // write port
  input  wire        wrUser,
  input  wire        wrMaster,
  input  wire [3:0]  wrAddr,
  input  wire [15:0] wrData,
  // read port
  input  wire [3:0]  rdAddr,
  output reg  [31:0] rdData
);
  reg  [31:0] mem [0:15];  // one word pair per entry
  // writes and registered read
  always @(posedge core_clk) begin
    if (ce) begin
      if (wrUser) begin
        mem[wrAddr][15:0] <= wrData;
      end
      if (wrMaster) begin
        mem[wrAddr][31:16] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule

// File: shared/dsef_regs.vh
// register map, command codes and field positions of the security command block
`ifndef DSEF_REGS_VH
`define DSEF_REGS_VH
// ****************************************
// register byte offsets
// ****************************************
`define DSEF_OFS_CMD    8'h00
`define DSEF_OFS_DATA   8'h04
`define DSEF_OFS_STAT   8'h08
`define DSEF_OFS_CTRL   8'h0C
`define DSEF_OFS_PWD    8'h10
// ****************************************
// command opcodes and monitoring features
// ****************************************
`define DSEF_OP_SETPW   8'hF1
`define DSEF_OP_UNLOCK  8'hF2
`define DSEF_OP_EPREP   8'hF3
`define DSEF_OP_ERASE   8'hF4
`define DSEF_OP_FREEZE  8'hF5
`define DSEF_OP_DISPW   8'hF6
`define DSEF_OP_SMART   8'hB0
`define DSEF_FT_FIRST   8'hD0
`define DSEF_FT_LOGW    8'hD6
`define DSEF_FT_ENA     8'hD8
`define DSEF_FT_LAST    8'hDB
// ****************************************
// sector layout and counters
// ****************************************
`define DSEF_WORD_LAST  8'hFF
`define DSEF_PW_FIRST   8'h01
`define DSEF_PW_LAST    8'h10
`define DSEF_TRIES      3'h5
// ****************************************
// status register fields
// ****************************************
`define DSEF_ST_BUSY    0
`define DSEF_ST_DRQ     1
`define DSEF_ST_ERR     2
`define DSEF_ST_ABRT    3
`define DSEF_ST_LOCKED  4
`define DSEF_ST_LOCKEN  5
`define DSEF_ST_FROZEN  6
`define DSEF_ST_ARMED   7
`define DSEF_ST_TRY_LO  8
`define DSEF_ST_OP_LO   12
// ****************************************
// control and password-load fields
// ****************************************
`define DSEF_CT_LOCKEN  0
`define DSEF_CT_LOCKED  1
`define DSEF_CT_MISS    2
`define DSEF_PW_IDX_LO  16
`define DSEF_PW_MASTER  20
`endif

// File: sim/drive_security_erase_freeze_fsm_tb.sv
// self-checking bench for the security erase and freeze command core
`timescale 1ns/100ps
`include "dsef_regs.vh"
module drive_security_erase_freeze_fsm_tb;
  // ****************************************
  // signals and counters
  // ****************************************
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hardRstn = 1'b1;
  logic        ce = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, cmdDone, cmdErr, eraseAll, smartGo;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  smartOp;
  int          error_cnt = 0, checks_done = 0, doneCnt = 0, eraseCnt = 0, smartCnt = 0;
  logic [7:0]  lockOps [6] = '{`DSEF_OP_SETPW, `DSEF_OP_UNLOCK, `DSEF_OP_EPREP,
                               `DSEF_OP_ERASE, `DSEF_OP_DISPW, 8'h00};
  always #2.5 core_clk = ~core_clk;
  // count completion and media pulses
  always @(posedge core_clk) begin
    doneCnt <= doneCnt + (cmdDone === 1'b1);
    eraseCnt <= eraseCnt + (eraseAll === 1'b1);
    smartCnt <= smartCnt + (smartGo === 1'b1);
  end
  dsef_core DUT (.core_clk, .rstn, .ce, .hardRstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cmdDone, .cmdErr,
    .eraseAll, .smartGo, .smartOp);
  dsef_host_model host (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);
  // ****************************************
  // compare, status and command tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [31:0] exp);
    host.xfer(1'b0, `DSEF_OFS_STAT, 32'h0, q);
    chk(q, exp);
  endtask
  // command write, sector when a base is given, bounded wait for one completion
  task automatic issue(input logic [7:0] op, input logic [7:0] ft, input logic err,
                       input logic sel = 1'b0, input logic [15:0] base = 16'h0000);
    int n, t;
    n = doneCnt;
    host.xfer(1'b1, `DSEF_OFS_CMD, {16'h0000, ft, op}, q);
    if (base != 16'h0000) host.sector(sel, base);
    for (t = 0; t < 100 && doneCnt == n; t++) @(posedge core_clk);
    chk({cmdErr, 31'(doneCnt - n)}, {err, 31'h1});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    st(32'h00000500);
    host.xfer(1'b1, 8'h20, 32'hFFFFFFFF, q);
    host.xfer(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h00000000);
    for (int i = 0; i < 16; i++) begin
      host.xfer(1'b1, `DSEF_OFS_PWD, {11'h000, 1'b0, 4'(i), 16'h1000 + 16'(i)}, q);
      host.xfer(1'b1, `DSEF_OFS_PWD, {11'h000, 1'b1, 4'(i), 16'h2000 + 16'(i)}, q);
    end
    issue(`DSEF_OP_ERASE, 8'h00, 1'b1);
    st(32'h0000050C);
    issue(`DSEF_OP_EPREP, 8'h00, 1'b0);
    st(32'h00000580);
    issue(`DSEF_OP_ERASE, 8'h00, 1'b1, 1'b0, 16'h3000);
    chk(eraseCnt, 0);
    host.xfer(1'b1, `DSEF_OFS_CTRL, 32'h1, q);
    issue(`DSEF_OP_EPREP, 8'h00, 1'b0);
    issue(`DSEF_OP_ERASE, 8'h00, 1'b0, 1'b1, 16'h2000);
    chk(eraseCnt, 1);
    st(32'h00000500);
    issue(`DSEF_OP_EPREP, 8'h00, 1'b0);
    issue(`DSEF_OP_SMART, 8'hDA, 1'b0);
    issue(`DSEF_OP_ERASE, 8'h00, 1'b1);
    for (int f = 8'hD0; f <= 8'hDB; f++) begin
      issue(`DSEF_OP_SMART, 8'(f), f == 8'hD7);
      chk({28'h0, smartOp}, {28'h0, (f == 8'hD7) ? 4'h6 : 4'(f)});
    end
    issue(`DSEF_OP_SMART, 8'hCF, 1'b1);
    chk(smartCnt, 12);
    // monitoring operation B stays visible in status from here until power-on reset
    host.xfer(1'b1, `DSEF_OFS_CTRL, 32'h3, q);
    host.xfer(1'b0, `DSEF_OFS_CTRL, 32'h0, q);
    chk(q, 32'h00000003);
    issue(`DSEF_OP_DISPW, 8'h00, 1'b1);
    host.xfer(1'b1, `DSEF_OFS_CTRL, 32'h1, q);
    issue(`DSEF_OP_DISPW, 8'h00, 1'b1, 1'b0, 16'h3000);
    st(32'h0000B52C);
    issue(`DSEF_OP_DISPW, 8'h00, 1'b0, 1'b1, 16'h1000);
    st(32'h0000B500);
    host.xfer(1'b1, `DSEF_OFS_CTRL, 32'h1, q);
    issue(`DSEF_OP_DISPW, 8'h00, 1'b0, 1'b0, 16'h2000);
    st(32'h0000B500);
    repeat (6) host.xfer(1'b1, `DSEF_OFS_CTRL, 32'h4, q);
    issue(`DSEF_OP_UNLOCK, 8'h00, 1'b1);
    issue(`DSEF_OP_EPREP, 8'h00, 1'b0);
    issue(`DSEF_OP_ERASE, 8'h00, 1'b1);
    st(32'h0000B00C);
    issue(`DSEF_OP_FREEZE, 8'h00, 1'b0);
    st(32'h0000B040);
    issue(`DSEF_OP_FREEZE, 8'h00, 1'b0);
    foreach (lockOps[k]) issue(lockOps[k], 8'h00, 1'b1);
    st(32'h0000B04C);
    // a hard reset pulse while the clock enable is low must leave no trace
    ce <= 1'b0;
    hardRstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    hardRstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    ce <= 1'b1;
    repeat (3) @(posedge core_clk);
    st(32'h0000B04C);
    hardRstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    hardRstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(32'h0000B50C);
    issue(`DSEF_OP_FREEZE, 8'h00, 1'b0);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    st(32'h00000500);
    print_verdict();
  end
endmodule

// File: sim/dsef_core_props.sv
// port checker for the security command core, bound into every core instance
`timescale 1ns/100ps
module dsef_core_props (
  // clock, reset, enable
  input logic        core_clk,
  input logic        rstn,
  input logic        ce,
  input logic        hardRstn,
  // register bus
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic [31:0] hrdata,
  input logic        hresp,
  // command and media outputs
  input logic        cmdDone,
  input logic        cmdErr,
  input logic        eraseAll,
  input logic        smartGo,
  input logic [3:0]  smartOp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // bus answers
  // ****************************************
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (ce && hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not answered after one wait");
  write_wait_a: assert property (ce && hsel && htrans[1] && hready && hwrite |=> !hreadyout)
    else $error("write taken without wait state");
  rdata_hold_a: assert property ($changed(hrdata) |-> hreadyout)
    else $error("read data moved mid transfer");
  // ****************************************
  // command completion
  // ****************************************
  done_pulse_a: assert property (cmdDone |=> !cmdDone)
    else $error("completion longer than one cycle");
  err_hold_a: assert property (!cmdDone |-> $stable(cmdErr))
    else $error("error flag moved without completion");
  erase_good_a: assert property (eraseAll |-> cmdDone && !cmdErr)
    else $error("erase without good completion");
  smart_good_a: assert property (smartGo |-> cmdDone && !cmdErr)
    else $error("monitoring start without good completion");
  smart_code_a: assert property (smartGo |-> smartOp != 4'h7 && smartOp <= 4'hB)
    else $error("monitoring operation out of range");
  // main scenarios seen
  cover property (eraseAll);
  cover property (smartGo);
  cover property (cmdDone && cmdErr);
endmodule
bind dsef_core dsef_core_props u_props (.core_clk, .rstn, .ce, .hardRstn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cmdDone,
  .cmdErr, .eraseAll, .smartGo, .smartOp);

// File: sim/dsef_host_model.sv
// host controller model: single-word bus transfers and password sectors
`timescale 1ns/100ps
`include "dsef_regs.vh"
module dsef_host_model (
  // clock and bus answer
  input  logic        core_clk,
  input  logic        hready,
  input  logic [31:0] hrdata,
  // bus request
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  // bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // address phase held until taken, then data phase held until answered
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
    q = hrdata;
  endtask
  // one whole sector: selector word, sixteen password words, reserved zeros
  task automatic sector(input logic sel, input logic [15:0] base);
    logic [31:0] q;
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin
      w = (i == 0) ? {15'h0000, sel} : (i <= 16) ? base + 16'(i - 1) : 16'h0000;
      xfer(1'b1, `DSEF_OFS_DATA, {16'h0000, w}, q);
    end
  endtask
endmodule
